//--- src/remote_setpoint_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the remote set-point block.
// Assumes: 200 MHz system clock; frequencies in 0.01 Hz units; ramp times in 0.1 s units.
// Notes: Definitions only.
`ifndef REMOTE_SETPOINT_MAP_VH
`define REMOTE_SETPOINT_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_SELECTOR 8'h00
`define OFS_EXT_ACCESS 8'h04
`define OFS_MODE 8'h08
`define OFS_MAX 8'h0c
`define OFS_RAMP1 8'h10
`define OFS_RAMP2 8'h14
`define OFS_REF 8'h18
`define OFS_STATUS 8'h1c
`define OFS_SETFREQ 8'h20
`define OFS_SAVED 8'h24

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define MODE_OP_MSB 2
`define MODE_ANALOG_BIT 4
`define MODE_HSMAX_BIT 5
`define SEL_MULTI 2'h0
`define SEL_SAVE 2'h1
`define SEL_NOSAVE 2'h2
`define SEL_STOPCLR 2'h3
`define OP_EXT 3'h0
`define OP_PANEL 3'h1
`define OP_COMBINED 3'h3
`define OP_EXT4 3'h4
`define OP_NETWORK 3'h6
`define DEC_SAME_AS_ACC 16'h270f
`define NV_WORD_SETPOINT 1'b0
`define NV_WORD_SELECTOR 1'b1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_MAX_NORMAL 16'h2ee0
`define RST_MAX_HIGH 16'h2ee0
`define RST_ACC 16'h0032
`define RST_DEC 16'h0032
`define RST_REF 16'h1388

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define TICK_TIME_US 1000
`define SAVE_PERIOD_MS 60000
`define RAMP_UNIT_MS 100
`define TICK_CYCLES (`TICK_TIME_US * 1000 / `CLK_PERIOD_NS)
`define MINUTE_TICKS (`SAVE_PERIOD_MS * 1000 / `TICK_TIME_US)
`define RAMP_UNIT_TICKS (`RAMP_UNIT_MS * 1000 / `TICK_TIME_US)

`endif

//--- src/contact_sync.v
// Purpose: Two-stage synchroniser for the contact inputs.
// Assumes: Inputs are slow levels from switches or a PLC.
// Notes: The first stage feeds only the second stage.
module contact_sync #(
  parameter W = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

//--- src/setpoint_nvstore.v
// Purpose: Two-word nonvolatile store for the saved set-point and the selector.
// Assumes: Contents survive the system reset, as a real nonvolatile part would.
// Notes: Registered read data; erase_i is a factory wipe of both words.
module setpoint_nvstore (
  input wire clk_i,
  input wire erase_i,
  input wire wr_i,
  input wire waddr_i,
  input wire [15:0] wdata_i,
  input wire raddr_i,
  output reg [15:0] rdata_o
);
  reg [15:0] word0_reg;
  reg [15:0] word1_reg;

  // No system reset here: keeping the words across reset is the whole point.
  always @(posedge clk_i) begin
    if (erase_i) begin
      word0_reg <= 16'h0000;
      word1_reg <= 16'h0000;
    end else if (wr_i) begin
      if (waddr_i) begin
        word1_reg <= wdata_i;
      end else begin
        word0_reg <= wdata_i;
      end
    end
    rdata_o <= raddr_i ? word1_reg : word0_reg;
  end
endmodule

//--- src/remote_setpoint.v
// Purpose: Digital motor potentiometer: contacts ramp a remote offset added to the base speed command.
// Assumes: Avalon-MM slave with one wait state; contacts are asynchronous; commands share MCLK_I.
// Notes: Operation
// Operation
// - Selector 1-3 makes contacts up, down, clear; 0 keeps multi-speed meaning.
// - Selector 3 never saves and zeroes the offset while both starts are off.
// - Only selector 1 saves; after power return the saved value is resumed.
// - Save on start release, and every minute after up/down last changed.
// - Periodic save writes only when the offset differs from the stored one.
// - The clear contact plays no part in the save decision.
// - Clear zeroes the working offset only, never the stored value.
// - Offset is held between zero and the active maximum frequency.
// - Set frequency is the base command plus the offset.
// - With second-ramp off, use second times unless first times are longer.
// - With second-ramp on, use the second times regardless.
// - Selectors 1 and 2 let up/down change the offset while stopped.
// - Base command follows the operation mode: external, combined or panel.
// - Jog or process loop control disables the remote function.
// - The remote function also works in network mode.
// - Power return within a minute of a clear resumes the previous saved value; the code stores the clear at the next periodic save, which can come sooner.
// - Power return after that minute resumes the cleared value.
// - In selector 1 an active start at power return restarts at the saved value.
// - Selector writes are accepted only while extended access is zero.
// - Second deceleration of 9999 means use the second acceleration time.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`include "remote_setpoint_map.vh"

module remote_setpoint #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter MINUTE_TICKS = `MINUTE_TICKS
) (
  // Clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // Avalon-MM slave
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  // Contacts from switches or a PLC
  input wire RAMP_UP_INPUT_I,
  input wire RAMP_DOWN_INPUT_I,
  input wire SETPOINT_CLEAR_INPUT_I,
  input wire FORWARD_START_INPUT_I,
  input wire REVERSE_START_INPUT_I,
  input wire SECOND_RAMP_SELECT_I,
  // Drive state and base commands
  input wire JOG_ACTIVE_I,
  input wire PROCESS_LOOP_ACTIVE_I,
  input wire [15:0] EXT_CMD_I,
  input wire [15:0] PANEL_CMD_I,
  input wire [15:0] ANALOG_CMD_I,
  input wire NV_ERASE_I,
  // Results
  output reg [16:0] SET_FREQ_O,
  output reg [2:0] MULTI_SPEED_O,
  output reg RUN_O
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function [15:0] max16;
    input [15:0] a;
    input [15:0] b;
    begin
      max16 = (a > b) ? a : b;
    end
  endfunction

  function [31:0] ramp_ticks;
    input [15:0] t;
    begin
      ramp_ticks = {16'h0000, ((t == 16'h0000) ? 16'h0001 : t)} * `RAMP_UNIT_TICKS;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[8*i +: 8] = din[8*i +: 8];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Contact synchronisers and nonvolatile store
  // ------------------------------------------------------------
  wire [5:0] contacts;
  wire up = contacts[0];
  wire down = contacts[1];
  wire clr = contacts[2];
  wire fwd = contacts[3];
  wire rev = contacts[4];
  wire rt = contacts[5];

  contact_sync #(.W(6)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .d_i({SECOND_RAMP_SELECT_I, REVERSE_START_INPUT_I, FORWARD_START_INPUT_I,
          SETPOINT_CLEAR_INPUT_I, RAMP_DOWN_INPUT_I, RAMP_UP_INPUT_I}),
    .q_o(contacts)
  );

  localparam ST_RD_SEL = 2'h0;
  localparam ST_RD_SP = 2'h1;
  localparam ST_LOAD = 2'h2;
  localparam ST_RUN = 2'h3;

  reg [1:0] state_reg;
  reg nv_wr;
  reg nv_waddr;
  reg [15:0] nv_wdata;
  wire [15:0] nv_rdata;

  setpoint_nvstore u_nv (
    .clk_i(MCLK_I),
    .erase_i(NV_ERASE_I),
    .wr_i(nv_wr),
    .waddr_i(nv_waddr),
    .wdata_i(nv_wdata),
    .raddr_i(state_reg == ST_RD_SEL),
    .rdata_o(nv_rdata)
  );

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [1:0] sel_reg;
  reg [7:0] access_reg;
  reg [5:0] mode_reg;
  reg [31:0] max_reg;
  reg [31:0] ramp1_reg;
  reg [31:0] ramp2_reg;
  reg [15:0] ref_reg;
  reg [15:0] offset_reg;
  reg [15:0] saved_reg;
  reg [15:0] wcount_reg;
  reg [31:0] acc_reg;
  reg [31:0] tick_cnt_reg;
  reg [31:0] min_cnt_reg;
  reg [1:0] ud_prev_reg;
  reg start_prev_reg;
  reg save_pend_reg;

  wire start_any = fwd | rev;
  wire running = (state_reg == ST_RUN);
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  wire remote_on = (sel_reg != `SEL_MULTI) && !JOG_ACTIVE_I && !PROCESS_LOOP_ACTIVE_I;
  wire [2:0] op = mode_reg[`MODE_OP_MSB:0];

  // ------------------------------------------------------------
  // Bus slave: one wait state, writes land at the edge that sees waitrequest low
  // ------------------------------------------------------------
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire bus_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire [31:0] wd = AVS_WRITEDATA_I;
  wire [3:0] be = AVS_BYTEENABLE_I;
  wire sel_wr = bus_wr && (AVS_ADDRESS_I == `OFS_SELECTOR) && (access_reg == 8'h00) && be[0];
  wire [31:0] sel_merged = merge({30'h0, sel_reg}, wd, be);

  reg [31:0] rdata;
  wire [31:0] wmerge = merge(rdata, wd, be);
  always @* begin
    case (AVS_ADDRESS_I)
      `OFS_SELECTOR: rdata = {30'h0, sel_reg};
      `OFS_EXT_ACCESS: rdata = {24'h0, access_reg};
      `OFS_MODE: rdata = {26'h0, mode_reg};
      `OFS_MAX: rdata = max_reg;
      `OFS_RAMP1: rdata = ramp1_reg;
      `OFS_RAMP2: rdata = ramp2_reg;
      `OFS_REF: rdata = {16'h0, ref_reg};
      `OFS_STATUS: rdata = {13'h0, save_pend_reg, running, remote_on, offset_reg};
      `OFS_SETFREQ: rdata = {15'h0, SET_FREQ_O};
      `OFS_SAVED: rdata = {wcount_reg, saved_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST_O <= !(req && AVS_WAITREQUEST_O && running);
      AVS_READDATA_O <= (AVS_READ_I && AVS_WAITREQUEST_O) ? rdata : AVS_READDATA_O;
    end
  end

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      access_reg <= 8'h00;
      mode_reg <= 6'h00;
      max_reg <= {`RST_MAX_HIGH, `RST_MAX_NORMAL};
      ramp1_reg <= {`RST_DEC, `RST_ACC};
      ramp2_reg <= {`DEC_SAME_AS_ACC, `RST_ACC};
      ref_reg <= `RST_REF;
    end else if (bus_wr) begin
      case (AVS_ADDRESS_I)
        `OFS_EXT_ACCESS: access_reg <= wmerge[7:0];
        `OFS_MODE: mode_reg <= wmerge[5:0];
        `OFS_MAX: max_reg <= wmerge;
        `OFS_RAMP1: ramp1_reg <= wmerge;
        `OFS_RAMP2: ramp2_reg <= wmerge;
        `OFS_REF: ref_reg <= wmerge[15:0];
        default: ref_reg <= ref_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Ramp rate, limit and base command
  // ------------------------------------------------------------
  wire [15:0] dec2_eff = (ramp2_reg[31:16] == `DEC_SAME_AS_ACC) ? ramp2_reg[15:0] : ramp2_reg[31:16];
  wire [15:0] acc_time = rt ? ramp2_reg[15:0] : max16(ramp1_reg[15:0], ramp2_reg[15:0]);
  wire [15:0] dec_time = rt ? dec2_eff : max16(ramp1_reg[31:16], dec2_eff);
  wire [15:0] max_f = mode_reg[`MODE_HSMAX_BIT] ? max_reg[31:16] : max_reg[15:0];
  wire dir_up = up && !down;
  wire dir_dn = down && !up;
  wire [31:0] step_len = ramp_ticks(dir_up ? acc_time : dec_time);
  wire can_step = (dir_up && offset_reg < max_f) || (dir_dn && offset_reg != 16'h0000);
  wire step = remote_on && can_step && (acc_reg >= step_len);

  reg [15:0] base;
  always @* begin
    case (op)
      `OP_EXT, `OP_EXT4, `OP_NETWORK: base = EXT_CMD_I;
      `OP_COMBINED: base = mode_reg[`MODE_ANALOG_BIT] ? ANALOG_CMD_I : PANEL_CMD_I;
      `OP_PANEL: base = PANEL_CMD_I;
      default: base = EXT_CMD_I;
    endcase
  end

  // ------------------------------------------------------------
  // Save request and nonvolatile write port
  // ------------------------------------------------------------
  wire ud_changed = (ud_prev_reg != {down, up});
  wire minute_hit = tick && (min_cnt_reg == MINUTE_TICKS - 1);
  wire start_fall = start_prev_reg && !start_any;
  wire save_trig = (sel_reg == `SEL_SAVE) && (start_fall || minute_hit);
  wire save_go = save_pend_reg && !sel_wr && running;

  always @* begin
    nv_wr = 1'b0;
    nv_waddr = `NV_WORD_SETPOINT;
    nv_wdata = offset_reg;
    if (sel_wr) begin
      nv_wr = 1'b1;
      nv_waddr = `NV_WORD_SELECTOR;
      nv_wdata = {14'h0, sel_merged[1:0]};
    end else if (save_go && (offset_reg != saved_reg)) begin
      nv_wr = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Restore sequence, timers and offset
  // ------------------------------------------------------------
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      state_reg <= ST_RD_SEL;
      sel_reg <= `SEL_MULTI;
      offset_reg <= 16'h0000;
      saved_reg <= 16'h0000;
      wcount_reg <= 16'h0000;
      acc_reg <= 32'h0000_0000;
      tick_cnt_reg <= 32'h0000_0000;
      min_cnt_reg <= 32'h0000_0000;
      ud_prev_reg <= 2'h0;
      start_prev_reg <= 1'b0;
      save_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RD_SEL: state_reg <= ST_RD_SP;
        ST_RD_SP: begin
          // The registered read port shows the selector word one cycle after it was addressed.
          sel_reg <= nv_rdata[1:0];
          state_reg <= ST_LOAD;
        end
        ST_LOAD: state_reg <= ST_RUN;
        ST_RUN: begin
          if (sel_reg == `SEL_SAVE && saved_reg != 16'h0000 && offset_reg == 16'h0000 && acc_reg == 32'h0) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RD_SEL;
      endcase
      if (state_reg == ST_LOAD) begin
        // Word 0 stands on the read port now; a power return resumes it only in the saving mode.
        saved_reg <= nv_rdata;
        offset_reg <= (sel_reg == `SEL_SAVE) ? nv_rdata : 16'h0000;
      end
      if (running) begin
        if (sel_wr) begin
          sel_reg <= sel_merged[1:0];
        end
        tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
        ud_prev_reg <= {down, up};
        start_prev_reg <= start_any;
        if (ud_changed) begin
          min_cnt_reg <= 32'h0000_0000;
        end else if (tick) begin
          min_cnt_reg <= minute_hit ? 32'h0000_0000 : min_cnt_reg + 32'h0000_0001;
        end
        // A new trigger wins over the one being served in the same cycle.
        if (save_trig) begin
          save_pend_reg <= 1'b1;
        end else if (save_go) begin
          save_pend_reg <= 1'b0;
        end
        if (save_go && offset_reg != saved_reg) begin
          saved_reg <= offset_reg;
          wcount_reg <= wcount_reg + 16'h0001;
        end
        // Step accumulator: each tick adds the reference, each step removes one ramp length.
        if (!remote_on || !(dir_up || dir_dn)) begin
          acc_reg <= 32'h0000_0000;
        end else begin
          acc_reg <= acc_reg + (tick ? {16'h0, ref_reg} : 32'h0) - (step ? step_len : 32'h0);
        end
        if (remote_on && clr) begin
          offset_reg <= 16'h0000;
        end else if (remote_on && sel_reg == `SEL_STOPCLR && !start_any) begin
          offset_reg <= 16'h0000;
        end else if (offset_reg > max_f) begin
          offset_reg <= max_f;
        end else if (step) begin
          offset_reg <= dir_up ? offset_reg + 16'h0001 : offset_reg - 16'h0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      SET_FREQ_O <= 17'h0_0000;
      MULTI_SPEED_O <= 3'h0;
      RUN_O <= 1'b0;
    end else begin
      SET_FREQ_O <= {1'b0, base} + (remote_on ? {1'b0, offset_reg} : 17'h0_0000);
      MULTI_SPEED_O <= (sel_reg == `SEL_MULTI) ? {clr, down, up} : 3'h0;
      RUN_O <= running && start_any;
    end
  end

endmodule

//--- verification/contact_panel.sv
// Purpose: Contact panel model standing in for the operator switches or PLC outputs.
// Assumes: The bench asks for contact levels as a mask, one bit a contact.
// Notes: Bits are {second ramp, reverse, forward, clear, down, up}.
module contact_panel (
  // Clock and request
  input wire logic clk_i,
  input wire logic [5:0] cmd_i,
  // Contacts
  output logic [5:0] contact_o = 6'h00
);
  // Contacts are levels that move only just after an edge, like a PLC output stage.
  always @(posedge clk_i) begin
    contact_o <= cmd_i;
  end
endmodule

//--- verification/remote_setpoint_chk.sv
// Purpose: Port-level checks of the remote set-point block.
// Assumes: Base commands stay steady while jog or loop control is on.
// Notes: Bound to the design from the bench top file.
`include "remote_setpoint_map.vh"
module remote_setpoint_chk (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Register bus
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Contacts and drive state
  input wire logic RAMP_UP_INPUT_I,
  input wire logic RAMP_DOWN_INPUT_I,
  input wire logic SETPOINT_CLEAR_INPUT_I,
  input wire logic FORWARD_START_INPUT_I,
  input wire logic REVERSE_START_INPUT_I,
  input wire logic JOG_ACTIVE_I,
  input wire logic PROCESS_LOOP_ACTIVE_I,
  input wire logic [15:0] EXT_CMD_I,
  input wire logic [15:0] PANEL_CMD_I,
  input wire logic [15:0] ANALOG_CMD_I,
  // Results
  input wire logic [16:0] SET_FREQ_O,
  input wire logic [2:0] MULTI_SPEED_O,
  input wire logic RUN_O
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  bus_one_cycle_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest stayed low");
  bus_answer_cause_a: assert property ($fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I))
    else $error("answer without request");
  unmapped_zero_a: assert property (!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I > `OFS_SAVED
    |-> AVS_READDATA_O == 32'h0) else $error("unmapped read not zero");
  selector_width_a: assert property (!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == `OFS_SELECTOR
    |-> AVS_READDATA_O[31:2] == 30'h0) else $error("selector upper bits set");
  multi_follow_a: assert property (MULTI_SPEED_O != 3'h0
    |-> MULTI_SPEED_O == {$past(SETPOINT_CLEAR_INPUT_I, 3), $past(RAMP_DOWN_INPUT_I, 3), $past(RAMP_UP_INPUT_I, 3)})
    else $error("multi speed not following contacts");
  remote_multi_off_a: assert property (!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == `OFS_STATUS
    && AVS_READDATA_O[16] |-> MULTI_SPEED_O == 3'h0) else $error("multi speed while remote active");
  remote_inhibit_a: assert property ((JOG_ACTIVE_I || PROCESS_LOOP_ACTIVE_I)[*4]
    |-> SET_FREQ_O == {1'b0, EXT_CMD_I} || SET_FREQ_O == {1'b0, PANEL_CMD_I} || SET_FREQ_O == {1'b0, ANALOG_CMD_I})
    else $error("offset applied while inhibited");
  stop_no_run_a: assert property ((!(FORWARD_START_INPUT_I || REVERSE_START_INPUT_I))[*4] |-> !RUN_O)
    else $error("running without start");
  start_runs_a: assert property ((FORWARD_START_INPUT_I || REVERSE_START_INPUT_I)[*8] |-> RUN_O)
    else $error("not running with start held");
endmodule

//--- verification/remote_speed_setpoint_potentiometer_test.sv
// Purpose: Self-checking bench for the remote set-point block.
// Assumes: Short tick and minute counts so a minute lasts 160 cycles.
// Notes: Ramp counts are checked within a small window, as the tick phase is free.
`include "remote_setpoint_map.vh"
module remote_speed_setpoint_potentiometer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic erase = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic [5:0] cmd = 6'h00;
  logic [5:0] contact;
  logic jog = 1'b0;
  logic loop_on = 1'b0;
  logic [3:0] be = 4'hf;
  logic [15:0] ext = 16'h03e8;
  logic [16:0] set_freq;
  logic [2:0] multi;
  logic run;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] r_addr [8] = '{`OFS_SELECTOR, `OFS_EXT_ACCESS, `OFS_MODE, `OFS_MAX, `OFS_RAMP1, `OFS_RAMP2, `OFS_REF, 8'h40};
  logic [31:0] r_val [8] = '{32'h0, 32'h0, 32'h0, 32'h2ee02ee0, 32'h00320032, 32'h270f0032, 32'h1388, 32'h0};
  logic [31:0] m_val [6] = '{32'h0, 32'h1, 32'h3, 32'h13, 32'h4, 32'h6};
  logic [31:0] m_exp [6] = '{32'h3e8, 32'h7d0, 32'h7d0, 32'hbb8, 32'h3e8, 32'h3e8};

  always #2.5 mclk = ~mclk;

  contact_panel panel (.clk_i(mclk), .cmd_i(cmd), .contact_o(contact));

  remote_setpoint #(.TICK_CYCLES(4), .MINUTE_TICKS(40)) dut (
    .MCLK_I(mclk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
    .RAMP_UP_INPUT_I(contact[0]), .RAMP_DOWN_INPUT_I(contact[1]), .SETPOINT_CLEAR_INPUT_I(contact[2]),
    .FORWARD_START_INPUT_I(contact[3]), .REVERSE_START_INPUT_I(contact[4]), .SECOND_RAMP_SELECT_I(contact[5]),
    .JOG_ACTIVE_I(jog), .PROCESS_LOOP_ACTIVE_I(loop_on), .EXT_CMD_I(ext), .PANEL_CMD_I(16'h07d0),
    .ANALOG_CMD_I(16'h0bb8), .NV_ERASE_I(erase), .SET_FREQ_O(set_freq), .MULTI_SPEED_O(multi), .RUN_O(run)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low; read data is taken at that edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_req !== 1'b0 && n < 200);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 200) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  task automatic offset_is(output logic [15:0] o);
    logic [31:0] q;
    xfer(1'b0, `OFS_STATUS, 32'h0, q);
    o = q[15:0];
  endtask

  task automatic hold(input logic [5:0] m, input int n);
    @(posedge mclk);
    cmd <= cmd | m;
    idle(n);
    cmd <= cmd & ~m;
    idle(8);
  endtask

  task automatic power;
    @(posedge mclk);
    rst <= 1'b1;
    idle(6);
    rst <= 1'b0;
    idle(16);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [15:0] o;
    logic [15:0] o1;
    logic [15:0] cnt;
    idle(6);
    rst <= 1'b0;
    erase <= 1'b0;
    idle(10);
    xfer(1'b1, 8'h40, 32'h12345678, q);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, r_addr[i], 32'h0, q);
      check("reset value", q, r_val[i]);
    end
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `OFS_SELECTOR, s, q);
      @(posedge mclk);
      cmd <= 6'h01;
      idle(24);
      check("multi speed", {29'h0, multi}, (s == 0) ? 32'h1 : 32'h0);
      cmd <= 6'h00;
      idle(8);
      offset_is(o);
      check("offset moved", {31'h0, o != 0}, {31'h0, s == 1 || s == 2});
      hold(6'h04, 4);
      offset_is(o);
      check("offset cleared", o, 32'h0);
    end
    xfer(1'b1, `OFS_EXT_ACCESS, 32'h1, q);
    xfer(1'b1, `OFS_SELECTOR, 32'h2, q);
    xfer(1'b0, `OFS_SELECTOR, 32'h0, q);
    check("selector locked", q, 32'h3);
    xfer(1'b1, `OFS_EXT_ACCESS, 32'h0, q);
    be <= 4'he;
    xfer(1'b1, `OFS_SELECTOR, 32'h1, q);
    be <= 4'hf;
    xfer(1'b0, `OFS_SELECTOR, 32'h0, q);
    check("lane 0 needed", q, 32'h3);
    // Heavy contact pulsing follows, so storage is switched off for it.
    xfer(1'b1, `OFS_SELECTOR, 32'h2, q);
    xfer(1'b1, `OFS_MAX, 32'h00640008, q);
    hold(6'h01, 200);
    check("set freq at limit", set_freq, 32'h3f0);
    xfer(1'b1, `OFS_MODE, 32'h20, q);
    hold(6'h01, 200);
    offset_is(o);
    check("high speed limit", {31'h0, o > 8 && o <= 100}, 32'h1);
    hold(6'h02, 800);
    check("lower limit", set_freq, 32'h3e8);
    xfer(1'b1, `OFS_RAMP1, 32'h00640064, q);
    hold(6'h01, 200);
    offset_is(o);
    check("first time longer", {31'h0, o >= 18 && o <= 28}, 32'h1);
    hold(6'h04, 4);
    hold(6'h21, 200);
    offset_is(o1);
    check("second time", {31'h0, o1 >= 42 && o1 <= 52}, 32'h1);
    hold(6'h22, 100);
    offset_is(o);
    check("decel as accel", {31'h0, o1 - o >= 20 && o1 - o <= 28}, 32'h1);
    hold(6'h04, 4);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, `OFS_MODE, m_val[i], q);
      idle(4);
      check("base command", set_freq, m_exp[i]);
    end
    ext <= 16'h0123;
    idle(4);
    check("network base", set_freq, 32'h123);
    ext <= 16'h03e8;
    hold(6'h01, 20);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      {loop_on, jog} <= 2'b01 << i;
      idle(6);
      check("remote inhibited", set_freq, 32'h3e8);
      {loop_on, jog} <= 2'b00;
      idle(6);
      check("remote back", {31'h0, set_freq > 17'h3e8}, 32'h1);
    end
    xfer(1'b1, `OFS_SELECTOR, 32'h3, q);
    idle(6);
    offset_is(o);
    check("stopped clears", o, 32'h0);
    @(posedge mclk);
    cmd <= 6'h08;
    hold(6'h01, 20);
    offset_is(o);
    check("ramps with start", {31'h0, o != 0}, 32'h1);
    @(posedge mclk);
    cmd <= 6'h00;
    idle(8);
    offset_is(o);
    check("start off clears", o, 32'h0);
    xfer(1'b1, `OFS_SELECTOR, 32'h1, q);
    @(posedge mclk);
    cmd <= 6'h08;
    hold(6'h01, 20);
    offset_is(o1);
    @(posedge mclk);
    cmd <= 6'h00;
    idle(8);
    xfer(1'b0, `OFS_SAVED, 32'h0, q);
    check("saved on stop", q[15:0], o1);
    hold(6'h04, 4);
    xfer(1'b0, `OFS_SAVED, 32'h0, q);
    check("store kept on clear", q[15:0], o1);
    @(posedge mclk);
    cmd <= 6'h08;
    power;
    offset_is(o);
    check("resumed saved", o, o1);
    check("restart", run, 32'h1);
    @(posedge mclk);
    cmd <= 6'h04;
    idle(400);
    xfer(1'b0, `OFS_SAVED, 32'h0, q);
    check("periodic save", q[15:0], 32'h0);
    cnt = q[31:16];
    idle(400);
    xfer(1'b0, `OFS_SAVED, 32'h0, q);
    check("no write when equal", q[31:16], cnt);
    @(posedge mclk);
    cmd <= 6'h00;
    power;
    offset_is(o);
    check("resumed cleared", o, 32'h0);
    check("no restart", run, 32'h0);
    tally_and_finish;
  end

  initial begin
    idle(20000);
    n_mismatch++;
    tally_and_finish;
  end
endmodule

bind remote_setpoint remote_setpoint_chk chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .RAMP_UP_INPUT_I(RAMP_UP_INPUT_I), .RAMP_DOWN_INPUT_I(RAMP_DOWN_INPUT_I),
  .SETPOINT_CLEAR_INPUT_I(SETPOINT_CLEAR_INPUT_I), .FORWARD_START_INPUT_I(FORWARD_START_INPUT_I),
  .REVERSE_START_INPUT_I(REVERSE_START_INPUT_I), .JOG_ACTIVE_I(JOG_ACTIVE_I),
  .PROCESS_LOOP_ACTIVE_I(PROCESS_LOOP_ACTIVE_I), .EXT_CMD_I(EXT_CMD_I), .PANEL_CMD_I(PANEL_CMD_I),
  .ANALOG_CMD_I(ANALOG_CMD_I), .SET_FREQ_O(SET_FREQ_O), .MULTI_SPEED_O(MULTI_SPEED_O), .RUN_O(RUN_O)
);
